/* File: dv/flash_dev_model.sv */
// behavioural parallel nor flash answering the host controller pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"

module flash_dev_model #(
	parameter int PROG_CYC = 80,
	parameter int ERASE_CYC = 200
) (
	// pins from the host
	input wire flash_host_pkg::fl_pins_t pins,
	input wire logic reset_n,
	input wire logic lvl_en,
	// pins to the host, plus count of host timing faults
	output var logic [`FL_DATA_W-1:0] dq,
	output var logic ready_busy,
	output var int viol
);
	import flash_host_pkg::*;
	logic [15:0] mem [logic [19:0]];
	logic [19:0] sa;
	logic [19:0] a;
	logic [19:0] q[$];
	logic [15:0] pd;
	logic [15:0] d;
	logic [15:0] hold = 16'h0000;
	logic busy = 1'b0;
	logic susp = 1'b0;
	logic tog = 1'b0;
	logic ce_up = 1'b1;
	logic ers;
	logic chip;
	logic was_busy;
	int seq = 0;
	int left = 0;
	int viol_n = 0;
	realtime t_rst = 0.0;
	realtime t_rel = -1000.0;
	realtime t_lvl = 0.0;

	// erased cells read as all ones
	function automatic logic [15:0] arr(input logic [19:0] k);
		return mem.exists(k) ? mem[k] : 16'hFFFF;
	endfunction

	assign viol = viol_n;
	// suspended erase frees the device for reads
	assign ready_busy = !busy || susp;

	// status while busy and not suspended, array otherwise; a released bus shows the inverse of its last value
	always @* begin
		if (!pins.ce_n && !pins.oe_n) begin
			dq = busy && !susp ? {8'h00, ~ers & ~pd[7], tog, 6'h00} : arr(pins.addr);
			hold = dq;
		end else begin
			dq = ~hold;
		end
	end

	// each status read needs its own chip-select pulse
	always @(negedge pins.oe_n) begin
		if ($realtime - t_rel < 49.9) viol_n++;
		if (!ce_up && busy) viol_n++;
		ce_up = 1'b0;
		if (busy && !susp) tog = ~tog;
	end
	always @(posedge pins.ce_n) ce_up = 1'b1;
	always @(posedge lvl_en) t_lvl = $realtime;

	// command cycles latch on the rising write strobe
	always @(posedge pins.we_n) begin
		a = pins.addr;
		d = pins.dq_o;
		if (lvl_en === 1'b1 && $realtime - t_lvl < 3999.9) viol_n++;
		if (busy) begin
			if (d == `CMD_SUSP && ers) susp = 1'b1;
			else if (d == `CMD_RESUME && susp) susp = 1'b0;
		end else case (seq)
			0, 4: seq = (a == `ADDR_UNLK1 && d == `CMD_UNLK1) ? seq + 1 : 0;
			1, 5: seq = (a == `ADDR_UNLK2 && d == `CMD_UNLK2) ? seq + 1 : 0;
			2: seq = d == `CMD_PROG ? 3 : (d == `CMD_ERASE ? 4 : 0);
			default: begin
				ers = seq == 6;
				chip = d == `CMD_CHIP;
				sa = ers ? a & `SECTOR_MASK : a;
				pd = d;
				busy = seq == 3 || chip || d == `CMD_SECT;
				left = ers ? ERASE_CYC : PROG_CYC;
				seq = 0;
			end
		endcase
	end

	// algorithm timebase; the result includes its own verify
	always #25 begin
		if (busy && !susp) left--;
		if (busy && left <= 0) begin
			busy = 1'b0;
			if (!ers) mem[sa] = arr(sa) & pd;
			q.delete();
			foreach (mem[k]) if (ers && (chip || (k & `SECTOR_MASK) == sa)) q.push_back(k);
			foreach (q[i]) mem.delete(q[i]);
		end
	end

	// reset aborts at once, so recovery is well inside both limits
	always @(negedge reset_n) begin
		t_rst = $realtime;
		was_busy = busy;
		busy = 1'b0;
		susp = 1'b0;
		seq = 0;
	end
	always @(posedge reset_n) begin
		if (was_busy === 1'b1 && $realtime - t_rst < 499.9) viol_n++;
		t_rel = $realtime;
	end
endmodule
`default_nettype wire

/* File: dv/flash_host_ctl_tb.sv */
// self-checking bench for the flash host controller against the device model
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"

module flash_host_ctl_tb;
	import flash_host_pkg::*;
	logic clk_sys;
	logic rstn;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic irq;
	fl_pins_t fl_pins;
	logic [15:0] fl_dq_i;
	logic [15:0] dev_dq;
	logic fl_ready_busy;
	logic fl_reset_n;
	logic fl_unprot_lvl_en;
	int viol;
	int n_fail = 0;
	int checked = 0;
	logic [31:0] v;

	// whoever enables its driver owns the data pins
	assign fl_dq_i = fl_pins.dq_oe ? fl_pins.dq_o : dev_dq;

	flash_host_ctl #(.SUSP_GAP_CYC(50)) i_flash_host_ctl (.clk_sys(clk_sys), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .fl_pins(fl_pins), .fl_dq_i(fl_dq_i),
		.fl_ready_busy(fl_ready_busy), .fl_reset_n(fl_reset_n),
		.fl_unprot_lvl_en(fl_unprot_lvl_en));
	flash_dev_model i_flash_dev_model (.pins(fl_pins), .reset_n(fl_reset_n),
		.lvl_en(fl_unprot_lvl_en), .dq(dev_dq), .ready_busy(fl_ready_busy), .viol(viol));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic summarize();
		$display("checks %0d fails %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			n_fail++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		// let the registers settle before anyone looks at an output
		#1;
	endtask

	// read data stand only in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, v);
	endtask

	task automatic op(input logic [19:0] a, input logic [15:0] d, input logic [3:0] c);
		wr(`REG_ADDR, {12'h000, a});
		wr(`REG_DATA, {16'h0000, d});
		wr(`REG_CTRL, {28'h0000000, c});
	endtask

	task automatic wait_idle();
		int i;
		for (i = 0; i < 5000; i++) begin
			rd(`REG_STATUS);
			if (v[0] === 1'b0) break;
		end
		chk("idle", 32'h0, {31'h0, v[0]});
	endtask

	task automatic rdback(input logic [19:0] a, input logic [15:0] e);
		op(a, 16'h0000, `OP_READ);
		wait_idle();
		rchk("array", `REG_DATA, {16'h0000, e});
	endtask

	task automatic t_reset();
		rchk("status", `REG_STATUS, 32'h2);
		rchk("unmapped", 8'h20, 32'h0);
		rchk("irq_stat", `REG_IRQ_STAT, 32'h0);
		$display("test reset values done");
	endtask

	// a second order while busy is refused; completion raises the interrupt
	task automatic t_prog();
		wr(`REG_IRQ_MASK, 32'h7);
		op(20'h01234, 16'h5AA5, `OP_PROG);
		wr(`REG_CTRL, {29'h0, `OP_SECT});
		wait_idle();
		chk("irq", 32'h1, {31'h0, irq});
		rchk("irq_stat", `REG_IRQ_STAT, 32'h5);
		wr(`REG_IRQ_STAT, 32'h5);
		chk("irq", 32'h0, {31'h0, irq});
		rdback(20'h01234, 16'h5AA5);
		op(20'h02000, 16'h00FF, `OP_PROG);
		wait_idle();
		rdback(20'h02000, 16'h00FF);
		$display("test program done");
	endtask

	// sector erase spares its neighbour, chip erase does not
	task automatic t_erase();
		op(20'h01FFF, 16'h0000, `OP_SECT);
		wait_idle();
		rdback(20'h01234, 16'hFFFF);
		rdback(20'h02000, 16'h00FF);
		op(20'h00000, 16'h0000, `OP_CHIP);
		wait_idle();
		rdback(20'h02000, 16'hFFFF);
		wr(`REG_IRQ_STAT, 32'h7);
		$display("test erase done");
	endtask

	task automatic t_abort();
		op(20'h03000, 16'h1234, `OP_PROG);
		repeat (30) @(posedge clk_sys);
		wr(`REG_CTRL, {29'h0, `OP_RESET});
		wait_idle();
		rchk("irq_stat", `REG_IRQ_STAT, 32'h2);
		wr(`REG_IRQ_STAT, 32'h7);
		rdback(20'h03000, 16'hFFFF);
		$display("test reset abort done");
	endtask

	task automatic t_unprot();
		op(20'h04000, 16'hA5A5, {1'b1, `OP_PROG});
		chk("unprot_lvl", 32'h1, {31'h0, fl_unprot_lvl_en});
		wait_idle();
		rdback(20'h04000, 16'hA5A5);
		$display("test unprotect done");
	endtask

	task automatic t_susp();
		op(20'h05000, 16'h0000, `OP_SECT);
		// the six command cycles take some 42 clocks; suspend only lands while polling
		repeat (80) @(posedge clk_sys);
		rd(`REG_STATUS);
		chk("ready pin", 32'h0, {31'h0, v[1]});
		wr(`REG_CTRL, {29'h0, `OP_SUSP});
		wait_idle();
		chk("suspended", 32'h1, {31'h0, v[3]});
		wr(`REG_CTRL, {29'h0, `OP_RESUME});
		wait_idle();
		chk("resumes", 32'h1, {21'h0, v[26:16]});
		chk("suspended", 32'h0, {31'h0, v[3]});
		rdback(20'h05000, 16'hFFFF);
		$display("test suspend done");
	endtask

	initial begin
		rstn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		// internal reset and the pin synchroniser need four edges to show the ready pin
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_prog();
		t_erase();
		t_abort();
		t_unprot();
		t_susp();
		chk("pin timing", 32'h0, viol);
		summarize();
	end

	// the whole run needs under 3k cycles; this limit of 80k cycles is over twenty-five times that
	initial begin
		#2000000;
		n_fail++;
		summarize();
	end
endmodule
`default_nettype wire

/* File: rtl/flash_bus_cycle.sv */
// single read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"

module flash_bus_cycle (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// request side
	input wire logic go,
	input wire flash_host_pkg::cyc_req_t req,
	output var logic done,
	output var logic [`FL_DATA_W-1:0] rdata,
	// pins
	input wire logic [`FL_DATA_W-1:0] dq_sync,
	output var flash_host_pkg::fl_pins_t pins
);
	import flash_host_pkg::*;

	typedef struct packed {
		cyc_phase_t phase;
		logic [3:0] cnt;
		logic is_rd;
		logic done;
		logic [`FL_DATA_W-1:0] rdata;
		fl_pins_t pins;
	} cyc_st_t;

	cyc_st_t s;
	cyc_st_t n;

	// ce always rises between cycles so status reads each see a fresh chip select
	always_comb begin
		n = s;
		n.done = 1'b0;
		case (s.phase)
			CY_IDLE: begin
				if (go) begin
					n.pins.addr = req.addr;
					n.pins.dq_o = req.data;
					n.pins.dq_oe = ~req.rd;
					n.pins.ce_n = 1'b0;
					n.pins.oe_n = ~req.rd;
					n.pins.we_n = req.rd;
					n.is_rd = req.rd;
					n.cnt = req.rd ? 4'(`ACC_CYC) : 4'(`WP_CYC);
					n.phase = CY_ACT;
				end
			end
			CY_ACT: begin
				if (s.cnt == 4'h1) begin
					// sample late enough to cover access time plus synchroniser
					if (s.is_rd) begin
						n.rdata = dq_sync;
					end
					n.pins.ce_n = 1'b1;
					n.pins.oe_n = 1'b1;
					n.pins.we_n = 1'b1;
					n.cnt = 4'(`WPH_CYC);
					n.phase = CY_REC;
				end else begin
					n.cnt = s.cnt - 4'h1;
				end
			end
			CY_REC: begin
				// address and data held through recovery for hold time
				if (s.cnt == 4'h1) begin
					n.pins.dq_oe = 1'b0;
					n.done = 1'b1;
					n.phase = CY_IDLE;
				end else begin
					n.cnt = s.cnt - 4'h1;
				end
			end
			default: begin
				n.phase = CY_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.pins.ce_n <= 1'b1;
			s.pins.oe_n <= 1'b1;
			s.pins.we_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign done = s.done;
	assign rdata = s.rdata;
	assign pins = s.pins;

	a_ce_between_reads: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		$fell(s.pins.oe_n) |-> $past(s.pins.ce_n) && !s.pins.ce_n)
		else $error("read started without chip select high before it");

	a_no_drive_on_read: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!s.pins.oe_n |-> !s.pins.dq_oe)
		else $error("data pins driven while device output enabled");
endmodule
`default_nettype wire

/* File: rtl/flash_host_cfg.svh */
// constants for the parallel nor flash host controller
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// pin widths
`define FL_ADDR_W 20
`define FL_DATA_W 16

// system clock period and rounding of least times to whole cycles
`define CLK_NS 25
`define CYC_MIN(ns) ((((ns)) + (`CLK_NS) - 1) / (`CLK_NS))

// pin timing, figures in their own units
`define T_WP_NS 35
`define T_WPH_NS 30
`define T_ACC_NS 90
`define T_RP_NS 500
`define T_RH_NS 50
`define T_ABORT_US 20
`define T_RSP_US 4
`define T_GAP_US 10000
`define SYNC_STAGES 2

// derived cycle counts
`define WP_CYC `CYC_MIN(`T_WP_NS)
`define WPH_CYC `CYC_MIN(`T_WPH_NS)
`define ACC_CYC (`CYC_MIN(`T_ACC_NS) + `SYNC_STAGES)
`define RP_CYC `CYC_MIN(`T_RP_NS)
`define RH_CYC `CYC_MIN(`T_RH_NS)
`define ABORT_CYC `CYC_MIN(`T_ABORT_US * 1000)
`define RSP_CYC `CYC_MIN(`T_RSP_US * 1000)
`define GAP_CYC `CYC_MIN(`T_GAP_US * 1000)
`define SUSP_LIMIT 11'h400

// software register byte offsets
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_STAT 8'h10
`define REG_IRQ_MASK 8'h14

// operation codes in the control register
`define OP_NONE 3'h0
`define OP_PROG 3'h1
`define OP_CHIP 3'h2
`define OP_SECT 3'h3
`define OP_READ 3'h4
`define OP_RESET 3'h5
`define OP_SUSP 3'h6
`define OP_RESUME 3'h7
`define CTRL_UNPROT_BIT 3

// interrupt status bits
`define IRQ_W 3
`define IRQ_DONE 0
`define IRQ_RST 1
`define IRQ_REFUSED 2

// status bit positions on the data pins
`define DP_BIT 7
`define TOG_BIT 6

// command cycles written to the device
`define ADDR_UNLK1 20'h00555
`define ADDR_UNLK2 20'h002AA
`define SECTOR_MASK 20'h7F000
`define CMD_UNLK1 16'h00AA
`define CMD_UNLK2 16'h0055
`define CMD_PROG 16'h00A0
`define CMD_ERASE 16'h0080
`define CMD_CHIP 16'h0010
`define CMD_SECT 16'h0030
`define CMD_SUSP 16'h00B0
`define CMD_RESUME 16'h0030

`endif

/* File: rtl/flash_host_ctl.sv */
// host controller driving a parallel nor flash through its pins
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"

module flash_host_ctl #(
	parameter int SUSP_GAP_CYC = `GAP_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// software register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output var logic [31:0] reg_rdata,
	output var logic irq,
	// flash pins
	output var flash_host_pkg::fl_pins_t fl_pins,
	input wire logic [`FL_DATA_W-1:0] fl_dq_i,
	input wire logic fl_ready_busy,
	output var logic fl_reset_n,
	output var logic fl_unprot_lvl_en
);
	import flash_host_pkg::*;

	localparam int RP_CYC_I = `RP_CYC;
	localparam int RSP_CYC_I = `RSP_CYC;

	typedef struct packed {
		host_state_t state;
		logic [2:0] op;
		logic unprot;
		logic [`FL_ADDR_W-1:0] tgt_addr;
		logic [`FL_DATA_W-1:0] wdata;
		logic [`FL_DATA_W-1:0] rd_data;
		logic [2:0] idx;
		logic go;
		logic pend;
		cyc_req_t req;
		logic prev_tog;
		logic have_prev;
		logic erase_act;
		logic susp_flag;
		logic susp_req;
		logic abort_wait;
		logic [9:0] cnt;
		logic [7:0] lvl_time;
		logic [19:0] gap_cnt;
		logic [10:0] susp_cnt;
		logic [`IRQ_W-1:0] irq_stat;
		logic [`IRQ_W-1:0] irq_mask;
		logic [31:0] rdata;
		logic fl_rst_n;
	} host_st_t;

	host_st_t s;
	host_st_t n;
	logic [1:0] rst_pipe;
	logic rst_sync_n;
	logic [`FL_DATA_W:0] pin_sync;
	logic cyc_done;
	logic [`FL_DATA_W-1:0] cyc_rdata;
	logic [4:0] rst_low_cnt;

	// reset released through two flops, asserted at once
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe[1];

	flash_pin_sync #(.W(`FL_DATA_W + 1)) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_sync_n),
		.din({fl_ready_busy, fl_dq_i}),
		.dout(pin_sync)
	);

	flash_bus_cycle u_cyc (
		.clk_sys(clk_sys),
		.rst_n(rst_sync_n),
		.go(s.go),
		.req(s.req),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.dq_sync(pin_sync[`FL_DATA_W-1:0]),
		.pins(fl_pins)
	);

	// command sequence table: unlock pair, command, then target or second unlock
	function automatic step_t seq_step(input logic [2:0] op, input logic [2:0] idx,
		input logic [`FL_ADDR_W-1:0] tgt, input logic [`FL_DATA_W-1:0] dat);
		step_t st;
		st.req.rd = 1'b0;
		st.last = 1'b0;
		st.req.addr = `ADDR_UNLK1;
		st.req.data = `CMD_UNLK1;
		if (op == `OP_SUSP || op == `OP_RESUME) begin
			st.req.addr = tgt;
			st.req.data = (op == `OP_SUSP) ? `CMD_SUSP : `CMD_RESUME;
			st.last = 1'b1;
		end else begin
			case (idx)
				3'h1, 3'h4: begin
					st.req.addr = `ADDR_UNLK2;
					st.req.data = `CMD_UNLK2;
				end
				3'h2: begin
					st.req.data = (op == `OP_PROG) ? `CMD_PROG : `CMD_ERASE;
				end
				3'h3: begin
					if (op == `OP_PROG) begin
						st.req.addr = tgt;
						st.req.data = dat;
						st.last = 1'b1;
					end
				end
				3'h5: begin
					// sector erase names the sector by the upper address bits
					st.req.addr = (op == `OP_SECT) ? (tgt & `SECTOR_MASK) : `ADDR_UNLK1;
					st.req.data = (op == `OP_SECT) ? `CMD_SECT : `CMD_CHIP;
					st.last = 1'b1;
				end
				default: begin
					st.req.data = `CMD_UNLK1;
				end
			endcase
		end
		return st;
	endfunction

	// register access, command acceptance and the sequencing state machine
	always_comb begin
		logic [2:0] cmd;
		logic accept;
		logic gap_ok;
		logic lvl_ready;
		logic dp_ok;
		logic tog;
		logic [`IRQ_W-1:0] ev;
		logic [`IRQ_W-1:0] w1c;
		step_t st;
		st = '0;
		cmd = `OP_NONE;
		accept = 1'b0;
		ev = '0;
		w1c = '0;
		dp_ok = 1'b0;
		tog = 1'b0;
		n = s;
		n.go = 1'b0;
		gap_ok = (s.susp_cnt < `SUSP_LIMIT) || (s.gap_cnt == 20'h0);
		lvl_ready = !s.unprot || (s.lvl_time == 8'(`RSP_CYC));
		if (s.gap_cnt != 20'h0) begin
			n.gap_cnt = s.gap_cnt - 20'h1;
		end
		// elevated level timer restarts whenever the level is dropped
		if (!s.unprot) begin
			n.lvl_time = 8'h0;
		end else if (!lvl_ready) begin
			n.lvl_time = s.lvl_time + 8'h1;
		end
		if (reg_wr) begin
			case (reg_addr)
				`REG_CTRL: begin
					cmd = reg_wdata[2:0];
					n.unprot = reg_wdata[`CTRL_UNPROT_BIT];
				end
				`REG_ADDR: n.tgt_addr = reg_wdata[`FL_ADDR_W-1:0];
				`REG_DATA: n.wdata = reg_wdata[`FL_DATA_W-1:0];
				`REG_IRQ_STAT: w1c = reg_wdata[`IRQ_W-1:0];
				`REG_IRQ_MASK: n.irq_mask = reg_wdata[`IRQ_W-1:0];
				default: cmd = `OP_NONE;
			endcase
		end
		// only suspend and reset may interrupt a running erase; others are refused unless idle
		case (cmd)
			`OP_NONE: accept = 1'b0;
			`OP_RESET: accept = 1'b1;
			`OP_SUSP: accept = (s.state == H_POLL) && s.erase_act && gap_ok && !s.susp_req;
			`OP_RESUME: accept = (s.state == H_IDLE) && s.susp_flag;
			default: accept = (s.state == H_IDLE);
		endcase
		if (cmd != `OP_NONE && !accept) begin
			ev[`IRQ_REFUSED] = 1'b1;
		end
		if (accept && cmd == `OP_RESET) begin
			n.state = H_RST_LO;
			n.fl_rst_n = 1'b0;
			n.cnt = 10'(`RP_CYC);
			n.pend = 1'b0;
			n.abort_wait = (s.state != H_IDLE) || !pin_sync[`FL_DATA_W];
		end else if (accept && cmd == `OP_SUSP) begin
			n.susp_req = 1'b1;
		end else if (accept) begin
			n.op = cmd;
			n.idx = 3'h0;
			n.have_prev = 1'b0;
			n.state = (cmd == `OP_READ) ? H_READ : H_SEQ;
		end else begin
			case (s.state)
				H_SEQ: begin
					st = seq_step(s.op, s.idx, s.tgt_addr, s.wdata);
					if (!s.pend && lvl_ready) begin
						n.go = 1'b1;
						n.pend = 1'b1;
						n.req = st.req;
					end else if (cyc_done) begin
						n.pend = 1'b0;
						n.idx = s.idx + 3'h1;
						if (st.last) begin
							n.state = H_POLL;
							n.have_prev = 1'b0;
							if (s.op == `OP_SUSP) begin
								n.susp_flag = 1'b1;
							end else if (s.op == `OP_RESUME) begin
								n.susp_flag = 1'b0;
								n.erase_act = 1'b1;
								if (s.susp_cnt != `SUSP_LIMIT) begin
									n.susp_cnt = s.susp_cnt + 11'h1;
								end
								if (s.susp_cnt + 11'h1 >= `SUSP_LIMIT) begin
									n.gap_cnt = 20'(SUSP_GAP_CYC);
								end
							end else begin
								n.erase_act = (s.op != `OP_PROG);
							end
						end
					end
				end
				H_POLL: begin
					if (!s.pend && s.susp_req) begin
						n.susp_req = 1'b0;
						n.op = `OP_SUSP;
						n.idx = 3'h0;
						n.state = H_SEQ;
					end else if (!s.pend) begin
						// status read at the target so the poll bit is meaningful
						n.go = 1'b1;
						n.pend = 1'b1;
						n.req.rd = 1'b1;
						n.req.addr = s.tgt_addr;
						n.req.data = '0;
					end else if (cyc_done) begin
						n.pend = 1'b0;
						tog = cyc_rdata[`TOG_BIT];
						case (s.op)
							`OP_PROG: dp_ok = cyc_rdata[`DP_BIT] == s.wdata[`DP_BIT];
							`OP_SUSP: dp_ok = 1'b1;
							default: dp_ok = cyc_rdata[`DP_BIT];
						endcase
						// finished when the toggle bit stands still and polling agrees
						if (s.have_prev && tog == s.prev_tog && dp_ok) begin
							n.state = H_IDLE;
							n.rd_data = cyc_rdata;
							n.erase_act = s.erase_act && (s.op == `OP_SUSP);
							// a suspend that arrives as the algorithm ends has nothing left to stop
							n.susp_req = 1'b0;
							ev[`IRQ_DONE] = 1'b1;
						end else begin
							n.prev_tog = tog;
							n.have_prev = 1'b1;
						end
					end
				end
				H_READ: begin
					if (!s.pend) begin
						n.go = 1'b1;
						n.pend = 1'b1;
						n.req.rd = 1'b1;
						n.req.addr = s.tgt_addr;
						n.req.data = '0;
					end else if (cyc_done) begin
						n.pend = 1'b0;
						n.rd_data = cyc_rdata;
						n.state = H_IDLE;
						ev[`IRQ_DONE] = 1'b1;
					end
				end
				H_RST_LO: begin
					if (s.cnt == 10'h1) begin
						n.fl_rst_n = 1'b1;
						n.cnt = s.abort_wait ? 10'(`ABORT_CYC - `RP_CYC) : 10'(`RH_CYC);
						n.state = H_RST_WAIT;
					end else begin
						n.cnt = s.cnt - 10'h1;
					end
				end
				H_RST_WAIT: begin
					if (s.cnt == 10'h1) begin
						n.state = H_IDLE;
						n.erase_act = 1'b0;
						n.susp_flag = 1'b0;
						n.susp_req = 1'b0;
						ev[`IRQ_RST] = 1'b1;
					end else begin
						n.cnt = s.cnt - 10'h1;
					end
				end
				default: n.state = H_IDLE;
			endcase
		end
		// a new event wins over a clear in the same cycle
		n.irq_stat = (s.irq_stat & ~w1c) | ev;
		if (reg_rd) begin
			case (reg_addr)
				`REG_CTRL: n.rdata = {28'h0, s.unprot, s.op};
				`REG_ADDR: n.rdata = {12'h0, s.tgt_addr};
				`REG_DATA: n.rdata = {16'h0, s.rd_data};
				`REG_STATUS: n.rdata = {5'h0, s.susp_cnt, 8'h0, 1'b0, s.state,
					s.susp_flag, s.erase_act, pin_sync[`FL_DATA_W], s.state != H_IDLE};
				`REG_IRQ_STAT: n.rdata = {29'h0, s.irq_stat};
				`REG_IRQ_MASK: n.rdata = {29'h0, s.irq_mask};
				default: n.rdata = 32'h0;
			endcase
		end else begin
			n.rdata = 32'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s <= '0;
			s.fl_rst_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign reg_rdata = s.rdata;
	assign irq = |(s.irq_stat & s.irq_mask);
	assign fl_reset_n = s.fl_rst_n;
	assign fl_unprot_lvl_en = s.unprot;

	// helper: length of the current reset low pulse, saturating
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rst_low_cnt <= 5'h0;
		end else if (s.fl_rst_n) begin
			rst_low_cnt <= 5'h0;
		end else if (rst_low_cnt != 5'h1F) begin
			rst_low_cnt <= rst_low_cnt + 5'h1;
		end
	end

	a_reset_pulse_len: assert property (
		@(posedge clk_sys) disable iff (!rst_sync_n)
		$rose(fl_reset_n) |-> rst_low_cnt >= RP_CYC_I)
		else $error("reset pulse shorter than minimum");

	a_read_after_reset: assert property (
		@(posedge clk_sys) disable iff (!rst_sync_n)
		$rose(fl_reset_n) |-> fl_pins.ce_n [*3])
		else $error("access too soon after reset release");

	a_unprot_setup: assert property (
		@(posedge clk_sys) disable iff (!rst_sync_n)
		(s.go && s.unprot) |-> s.lvl_time >= RSP_CYC_I)
		else $error("command issued before unprotect level setup");

	a_suspend_gap: assert property (
		@(posedge clk_sys) disable iff (!rst_sync_n)
		(s.go && s.op == `OP_SUSP) |-> (s.susp_cnt < `SUSP_LIMIT || s.gap_cnt == 20'h0))
		else $error("suspend issued inside the erase progress gap");

	a_poll_target: assert property (
		@(posedge clk_sys) disable iff (!rst_sync_n)
		(s.go && s.state == H_POLL) |-> s.req.rd && s.req.addr == s.tgt_addr)
		else $error("status read not at target location");

	a_irq_level: assert property (
		@(posedge clk_sys) disable iff (!rst_sync_n)
		(s.irq_stat[`IRQ_DONE] && s.irq_mask[`IRQ_DONE]) |-> irq)
		else $error("interrupt low with unmasked done pending");
endmodule
`default_nettype wire

/* File: rtl/flash_host_pkg.sv */
// types shared by the flash host controller modules
`include "flash_host_cfg.svh"

package flash_host_pkg;

	// flash pins driven by the controller
	typedef struct packed {
		logic [`FL_ADDR_W-1:0] addr;
		logic [`FL_DATA_W-1:0] dq_o;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} fl_pins_t;

	// one bus cycle request
	typedef struct packed {
		logic rd;
		logic [`FL_ADDR_W-1:0] addr;
		logic [`FL_DATA_W-1:0] data;
	} cyc_req_t;

	// one step of a command sequence
	typedef struct packed {
		cyc_req_t req;
		logic last;
	} step_t;

	typedef enum logic [1:0] {CY_IDLE, CY_ACT, CY_REC} cyc_phase_t;

	typedef enum logic [2:0] {H_IDLE, H_SEQ, H_POLL, H_READ, H_RST_LO, H_RST_WAIT} host_state_t;

endpackage

/* File: rtl/flash_pin_sync.sv */
// two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
`default_nettype none

module flash_pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// pins in, synchronised copy out
	input wire logic [W-1:0] din,
	output var logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} sync_st_t;

	sync_st_t s;
	sync_st_t n;

	// first stage is read only by the second stage
	always_comb begin
		n.meta = din;
		n.sync = s.meta;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign dout = s.sync;
endmodule
`default_nettype wire
